// [rtl/cc_branch_eval.sv]
// Purpose: Branch condition evaluation from the condition code register
// Assumes: Purely combinational, registered by the caller
// Notes: Bit tests cover every bit of the register
`timescale 1ns/1ps
module cc_branch_eval
    import cc_flags_pkg::*;
(
    input wire logic [CC_W-1:0] cc_i,
    input wire branch_req_s req_i,
    output logic taken_o
);

    function automatic logic cond_true(input logic [CC_W-1:0] cc, input cond_e c,
                                       input logic [2:0] sel);
        case (c)
            COND_H: cond_true = cc[CC_H_BIT];
            COND_NH: cond_true = ~cc[CC_H_BIT];
            COND_MI: cond_true = cc[CC_N_BIT];
            COND_PL: cond_true = ~cc[CC_N_BIT];
            COND_EQ: cond_true = cc[CC_Z_BIT];
            COND_NE: cond_true = ~cc[CC_Z_BIT];
            COND_C: cond_true = cc[CC_C_BIT];
            COND_NC: cond_true = ~cc[CC_C_BIT];
            COND_BSET: cond_true = cc[sel];
            COND_BCLR: cond_true = ~cc[sel];
            default: cond_true = 1'b0;
        endcase
    endfunction

    always_comb
    begin
        taken_o = req_i.valid & cond_true(cc_i, req_i.cond, req_i.bit_sel);
    end

endmodule // cc_branch_eval

// [rtl/cpu_condition_code_flags.sv]
// Purpose: Condition code register and flag update logic of the core
// Assumes: Decoder presents one flag command per cycle at instruction end
// Notes: Core updates win over a software write in the same cycle
//
// Function
// - 8-bit register holding priority bits and four flags, reset 111x1xxx.
// - Whole register can be pushed to and popped from the stack.
// - Every bit can be tested or modified by dedicated instructions; bits 7 and 6 stay at one whatever is written.
// - Add and add-with-carry set half carry on carry from bit 3.
// - Same instructions clear half carry otherwise; others leave it unchanged.
// - Half carry drives branch-if-half-carry and branch-if-no-half-carry.
// - Arithmetic, logic and data operations copy result bit 7 into negative.
// - Negative drives branch-if-minus and branch-if-plus.
// - Zero flag set when result is zero, cleared otherwise; used by branches.
// - Carry records arithmetic overflow, set/reset, bit test, shift and rotate.
// - Bits 5 and 3 encode priority: 10 lvl0, 01 lvl1, 00 lvl2, 11 lvl3.
//
// The placing of the registers and the strobed register port were chosen for this implementation.
`timescale 1ns/1ps
module cpu_condition_code_flags
    import cc_flags_pkg::*;
(
    input wire logic mclk_i,
    input wire logic rst_n_i,
    input wire logic upd_valid_i,
    input wire flag_upd_s upd_i,
    input wire branch_req_s branch_i,
    input wire bus_req_s bus_i,
    output logic [CC_W-1:0] rdata_o,
    output logic [CC_W-1:0] cc_o,
    output logic branch_taken_o,
    output logic branch_valid_o,
    output logic [1:0] prio_level_o,
    output logic irq_disable_o
);

    typedef struct packed {
        logic [CC_W-1:0] cc;
        logic [CC_W-1:0] rdata;
        logic taken;
        logic taken_vld;
        logic [1:0] level;
        logic irq_dis;
    } state_s;

    localparam state_s STATE_RESET = '{
        cc: CC_RESET,
        rdata: 8'h00,
        taken: 1'b0,
        taken_vld: 1'b0,
        level: 2'h3,
        irq_dis: 1'b1
    };

    logic [1:0] rst_sync_r;
    logic rst_n;
    state_s state_r;
    state_s state_nxt;
    logic taken_comb;

    // Release of the asynchronous reset is synchronised to the core clock
    always_ff @(posedge mclk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            rst_sync_r <= RST_SYNC_INIT;
        end
        else
        begin
            rst_sync_r <= {rst_sync_r[0], 1'b1};
        end
    end

    assign rst_n = rst_sync_r[1];

    // Decode the priority pair into a level number
    function automatic logic [1:0] prio_to_level(
        input logic [1:0] pair
    );
        case (pair)
            PRIO_LVL0:
            begin
                prio_to_level = 2'h0;
            end
            PRIO_LVL1:
            begin
                prio_to_level = 2'h1;
            end
            PRIO_LVL2:
            begin
                prio_to_level = 2'h2;
            end
            default:
            begin
                prio_to_level = 2'h3;
            end
        endcase
    endfunction

    // Only the top level masks interrupts
    function automatic logic level_disables(
        input logic [1:0] level
    );
        return (level == 2'h3);
    endfunction

    // The register answers at one address only
    function automatic logic cc_selected(
        input logic [ADDR_W-1:0] addr
    );
        return (addr == CC_OFFSET);
    endfunction

    // One-hot mask of a single register bit
    function automatic logic [CC_W-1:0] bit_mask(
        input logic [2:0] sel
    );
        case (sel)
            3'h0: bit_mask = 8'h01;
            3'h1: bit_mask = 8'h02;
            3'h2: bit_mask = 8'h04;
            3'h3: bit_mask = 8'h08;
            3'h4: bit_mask = 8'h10;
            3'h5: bit_mask = 8'h20;
            3'h6: bit_mask = 8'h40;
            3'h7: bit_mask = 8'h80;
            default: bit_mask = 8'h00;
        endcase
    endfunction

    // Bits 7 and 6 have no storage, so they read as one whatever was loaded
    function automatic logic [CC_W-1:0] fixed_bits(
        input logic [CC_W-1:0] cc
    );
        return cc | CC_FIXED_ONES;
    endfunction

    // Sign and zero follow the result of every arithmetic, logic and data operation
    function automatic logic [CC_W-1:0] result_flags(
        input logic [CC_W-1:0] cc,
        input logic [CC_W-1:0] result
    );
        logic [CC_W-1:0] flags;
        flags = cc;
        flags[CC_N_BIT] = result[RESULT_MSB];
        flags[CC_Z_BIT] = (result == 8'h00);
        return flags;
    endfunction

    // Carry takes the carry or borrow out, the shifted-out bit or the tested bit
    function automatic logic [CC_W-1:0] carry_flag(
        input logic [CC_W-1:0] cc,
        input logic carry
    );
        logic [CC_W-1:0] flags;
        flags = cc;
        flags[CC_C_BIT] = carry;
        return flags;
    endfunction

    // One flag command applied on top of the register value
    function automatic logic [CC_W-1:0] apply_update(
        input logic [CC_W-1:0] cc_in,
        input flag_upd_s upd
    );
        logic [CC_W-1:0] cc;
        cc = cc_in;
        case (upd.op)
            OP_ADD, OP_ADC:
            begin
                cc[CC_H_BIT] = upd.carry3;
                cc = result_flags(cc, upd.result);
                cc = carry_flag(cc, upd.carry7);
            end
            OP_SUB:
            begin
                // Half carry is left alone on a subtract
                cc = result_flags(cc, upd.result);
                cc = carry_flag(cc, upd.carry7);
            end
            OP_LOGIC, OP_DATA:
            begin
                cc = result_flags(cc, upd.result);
            end
            OP_SHIFT:
            begin
                cc = result_flags(cc, upd.result);
                cc = carry_flag(cc, upd.carry7);
            end
            OP_BTJ:
            begin
                cc = carry_flag(cc, upd.carry7);
            end
            OP_SCF:
            begin
                cc = carry_flag(cc, 1'b1);
            end
            OP_RCF:
            begin
                cc = carry_flag(cc, 1'b0);
            end
            OP_POP:
            begin
                // Whole register comes back from the stack
                cc = upd.result;
            end
            OP_BITMOD:
            begin
                if (upd.bit_val)
                begin
                    cc = cc | bit_mask(upd.bit_sel);
                end
                else
                begin
                    cc = cc & ~bit_mask(upd.bit_sel);
                end
            end
            OP_PRIO:
            begin
                cc[CC_I1_BIT] = upd.prio[1];
                cc[CC_I0_BIT] = upd.prio[0];
            end
            default:
            begin
                // Unknown commands leave every flag as it was
                cc = cc_in;
            end
        endcase
        return cc;
    endfunction

    // Branch sees the register as it stands, i.e. after the previous update
    cc_branch_eval u_branch_eval (
        .cc_i(state_r.cc),
        .req_i(branch_i),
        .taken_o(taken_comb)
    );

    always_comb
    begin
        logic [CC_W-1:0] cc;
        logic [1:0] level;
        cc = state_r.cc;
        level = 2'h3;
        state_nxt = state_r;

        // Software write first so a same-cycle core update overrides it
        if (bus_i.wr && cc_selected(bus_i.addr))
        begin
            cc = bus_i.wdata;
        end

        if (upd_valid_i)
        begin
            cc = apply_update(cc, upd_i);
        end

        // Unused top bits stay at one whatever is written or popped
        cc = fixed_bits(cc);
        state_nxt.cc = cc;

        // Level comes from the next value so it never lags the register
        level = prio_to_level({cc[CC_I1_BIT], cc[CC_I0_BIT]});
        state_nxt.level = level;
        state_nxt.irq_dis = level_disables(level);

        // Read data stand for one cycle only and are zero otherwise
        if (bus_i.rd)
        begin
            if (cc_selected(bus_i.addr))
            begin
                state_nxt.rdata = state_r.cc;
            end
            else
            begin
                state_nxt.rdata = UNMAPPED_READ;
            end
        end
        else
        begin
            state_nxt.rdata = 8'h00;
        end

        // Branch answer is registered, so it stands for one cycle after the request
        if (branch_i.valid)
        begin
            state_nxt.taken = taken_comb;
        end
        else
        begin
            state_nxt.taken = 1'b0;
        end
        state_nxt.taken_vld = branch_i.valid;
    end

    always_ff @(posedge mclk_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_r <= STATE_RESET;
        end
        else
        begin
            state_r <= state_nxt;
        end
    end

    assign rdata_o = state_r.rdata;
    assign cc_o = state_r.cc;
    assign branch_taken_o = state_r.taken;
    assign branch_valid_o = state_r.taken_vld;
    assign prio_level_o = state_r.level;
    assign irq_disable_o = state_r.irq_dis;

endmodule // cpu_condition_code_flags

// [shared/cc_flags_pkg.sv]
// Purpose: Shared constants and types for the condition code flag block
// Assumes: 8-bit core, one clock, flag commands come from the decoder
// Notes: Undefined reset bits are taken as zero
package cc_flags_pkg;

    localparam int CC_W = 8;
    localparam int ADDR_W = 4;

    // Bit positions in the condition code register
    localparam int CC_C_BIT = 0;
    localparam int CC_Z_BIT = 1;
    localparam int CC_N_BIT = 2;
    localparam int CC_I0_BIT = 3;
    localparam int CC_H_BIT = 4;
    localparam int CC_I1_BIT = 5;
    localparam int RESULT_MSB = 7;

    // Reset 111x1xxx with the undefined bits taken as zero
    localparam logic [CC_W-1:0] CC_RESET = 8'he8;
    // Bits 7 and 6 are unused and always read as one
    localparam logic [CC_W-1:0] CC_FIXED_ONES = 8'hc0;

    localparam logic [ADDR_W-1:0] CC_OFFSET = 4'h0;
    localparam logic [CC_W-1:0] UNMAPPED_READ = 8'h00;

    // Priority pair written as {priority_bit_high, priority_bit_low}
    localparam logic [1:0] PRIO_LVL0 = 2'b10;
    localparam logic [1:0] PRIO_LVL1 = 2'b01;
    localparam logic [1:0] PRIO_LVL2 = 2'b00;
    localparam logic [1:0] PRIO_LVL3 = 2'b11;

    localparam logic [1:0] RST_SYNC_INIT = 2'b00;

    typedef enum logic [3:0] {
        OP_NONE   = 4'b0000,
        OP_ADD    = 4'b0001,
        OP_ADC    = 4'b0010,
        OP_SUB    = 4'b0011,
        OP_LOGIC  = 4'b0100,
        OP_DATA   = 4'b0101,
        OP_SHIFT  = 4'b0110,
        OP_BTJ    = 4'b0111,
        OP_SCF    = 4'b1000,
        OP_RCF    = 4'b1001,
        OP_POP    = 4'b1010,
        OP_BITMOD = 4'b1011,
        OP_PRIO   = 4'b1100
    } flag_op_e;

    typedef enum logic [3:0] {
        COND_NONE = 4'b0000,
        COND_H    = 4'b0001,
        COND_NH   = 4'b0010,
        COND_MI   = 4'b0011,
        COND_PL   = 4'b0100,
        COND_EQ   = 4'b0101,
        COND_NE   = 4'b0110,
        COND_C    = 4'b0111,
        COND_NC   = 4'b1000,
        COND_BSET = 4'b1001,
        COND_BCLR = 4'b1010
    } cond_e;

    typedef struct packed {
        flag_op_e op;
        logic [CC_W-1:0] result;
        logic carry3;
        logic carry7;
        logic [2:0] bit_sel;
        logic bit_val;
        logic [1:0] prio;
    } flag_upd_s;

    typedef struct packed {
        logic valid;
        cond_e cond;
        logic [2:0] bit_sel;
    } branch_req_s;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [CC_W-1:0] wdata;
        logic wr;
        logic rd;
    } bus_req_s;

endpackage

// [tb/cc_alu_model.sv]
// Purpose: Decoder and ALU stand-in
// Assumes: r_i holds operands and fields
// Notes: Only adds compute; other fields pass through
`timescale 1ns/1ps
module cc_alu_model
    import cc_flags_pkg::*;
(
    input wire flag_op_e op_i,
    input wire logic [31:0] r_i,
    output flag_upd_s upd_o
);
    logic cin;
    logic [4:0] lo;
    logic [8:0] sum;
    always_comb
    begin
        cin = (op_i == OP_ADC) & r_i[16];
        lo = {1'b0, r_i[3:0]} + {1'b0, r_i[11:8]} + {4'h0, cin};
        sum = {1'b0, r_i[7:0]} + {1'b0, r_i[15:8]} + {8'h0, cin};
        upd_o = '{op_i, r_i[7:0], r_i[17], r_i[18], r_i[21:19], r_i[22], r_i[24:23]};
        if (op_i inside {OP_ADD, OP_ADC})
        begin
            upd_o.result = sum[7:0];
            upd_o.carry3 = lo[4];
            upd_o.carry7 = sum[8];
        end
    end
endmodule // cc_alu_model

// [tb/cc_flags_checker.sv]
// Purpose: Port assertions
// Assumes: One clock domain
// Notes: Quiet while reset is low
`timescale 1ns/1ps
module cc_flags_checker
    import cc_flags_pkg::*;
(
    input wire logic mclk_i,
    input wire logic rst_n_i,
    input wire logic upd_valid_i,
    input wire flag_upd_s upd_i,
    input wire branch_req_s branch_i,
    input wire logic [CC_W-1:0] cc_o,
    input wire logic branch_taken_o,
    input wire logic branch_valid_o,
    input wire logic [1:0] prio_level_o,
    input wire logic irq_disable_o
);
    default clocking @(posedge mclk_i); endclocking
    default disable iff (!rst_n_i);
    logic add_w, res_w;
    assign add_w = upd_valid_i && upd_i.op inside {OP_ADD, OP_ADC};
    assign res_w = add_w || upd_valid_i && upd_i.op inside {OP_SUB, OP_LOGIC, OP_DATA, OP_SHIFT};
    chk_half_add: assert property (add_w |=>
        cc_o[CC_H_BIT] == $past(upd_i.carry3)) else $error("half carry");
    chk_neg_copy: assert property (res_w |=>
        cc_o[CC_N_BIT] == $past(upd_i.result[7])) else $error("negative");
    chk_zero_res: assert property (res_w |=> cc_o[CC_Z_BIT] ==
        ($past(upd_i.result) == 8'h00)) else $error("zero");
    chk_carry_cmd: assert property (upd_valid_i && upd_i.op inside {OP_SCF, OP_RCF}
        |=> cc_o[CC_C_BIT] == ($past(upd_i.op) == OP_SCF)) else $error("carry");
    chk_pop_whole: assert property (upd_valid_i && upd_i.op == OP_POP
        |=> cc_o == ($past(upd_i.result) | CC_FIXED_ONES)) else $error("pop");
    chk_br_half: assert property (branch_i.valid && branch_i.cond == COND_H
        |=> branch_valid_o && branch_taken_o == $past(cc_o[CC_H_BIT])) else $error("br h");
    chk_br_plus: assert property (branch_i.valid && branch_i.cond == COND_PL
        |=> branch_valid_o && branch_taken_o != $past(cc_o[CC_N_BIT])) else $error("br pl");
    chk_prio_map: assert property (irq_disable_o == &prio_level_o && prio_level_o ==
        {~(cc_o[CC_I1_BIT] ^ cc_o[CC_I0_BIT]), cc_o[CC_I0_BIT]}) else $error("prio");
endmodule // cc_flags_checker

bind cpu_condition_code_flags cc_flags_checker cc_flags_checker_i (.mclk_i(mclk_i),
    .rst_n_i(rst_n_i), .upd_valid_i(upd_valid_i), .upd_i(upd_i), .branch_i(branch_i),
    .cc_o(cc_o), .branch_taken_o(branch_taken_o), .branch_valid_o(branch_valid_o),
    .prio_level_o(prio_level_o), .irq_disable_o(irq_disable_o));

// [tb/cpu_condition_code_flags_bench.sv]
// Purpose: Self-checking bench
// Assumes: Inputs change by NBA at the rising edge
// Notes: Expected values come from a bench model
`timescale 1ns/1ps
module cpu_condition_code_flags_bench
    import cc_flags_pkg::*;
();
    logic mclk_i = 0, rst_n_i = 0, upd_valid_i = 0, rd_d = 0;
    flag_op_e op = OP_NONE;
    logic [31:0] r = '0, s = 32'h20222355;
    flag_upd_s upd_i;
    branch_req_s branch_i = '0;
    bus_req_s bus_i = '0;
    logic [7:0] rdata_o, cc_o, m, q[$];
    logic branch_taken_o, branch_valid_o, irq_disable_o;
    logic [1:0] prio_level_o;
    int err_count = 0, cmp_count = 0, n = 0;
    always #5 mclk_i = ~mclk_i;
    cc_alu_model cc_alu_model_i (.op_i(op), .r_i(r), .upd_o(upd_i));
    cpu_condition_code_flags cpu_condition_code_flags_i (.mclk_i(mclk_i), .rst_n_i(rst_n_i),
        .upd_valid_i(upd_valid_i), .upd_i(upd_i), .branch_i(branch_i), .bus_i(bus_i),
        .rdata_o(rdata_o), .cc_o(cc_o), .branch_taken_o(branch_taken_o),
        .branch_valid_o(branch_valid_o), .prio_level_o(prio_level_o),
        .irq_disable_o(irq_disable_o));
    function automatic logic [31:0] xs(logic [31:0] x);
        x ^= x << 13;
        x ^= x >> 17;
        x ^= x << 5;
        return x;
    endfunction
    function automatic logic [7:0] nxt(logic [7:0] c, flag_upd_s u);
        if (u.op inside {OP_ADD, OP_ADC}) c[4] = u.carry3;
        if (u.op inside {OP_ADD, OP_ADC, OP_SUB, OP_SHIFT, OP_BTJ}) c[0] = u.carry7;
        if (u.op inside {OP_SCF, OP_RCF}) c[0] = u.op == OP_SCF;
        if (u.op inside {OP_ADD, OP_ADC, OP_SUB, OP_LOGIC, OP_DATA, OP_SHIFT})
            c[2:1] = {u.result[7], u.result == 8'h00};
        if (u.op == OP_BITMOD) c[u.bit_sel] = u.bit_val;
        if (u.op == OP_PRIO) {c[5], c[3]} = u.prio;
        return (u.op == OP_POP ? u.result : c) | CC_FIXED_ONES;
    endfunction
    function automatic logic tk(logic [7:0] c, branch_req_s b);
        int k;
        k = b.cond inside {COND_H, COND_NH} ? 4 : b.cond inside {COND_MI, COND_PL} ? 2 :
            b.cond inside {COND_EQ, COND_NE} ? 1 : b.cond inside {COND_C, COND_NC} ? 0 : b.bit_sel;
        return c[k] ^ (b.cond inside {COND_NH, COND_PL, COND_NE, COND_NC, COND_BCLR});
    endfunction
    task automatic print_verdict();
        if (q.size() > 0) err_count++;
        $display("compares %0d errors %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task automatic cmp(logic [7:0] g);
        logic [7:0] e;
        e = q.size() > 0 ? q.pop_front() : 8'hxx;
        cmp_count++;
        if (g !== e)
        begin
            err_count++;
            $display("[ERR] %0t got %h exp %h", $time, g, e);
        end
    endtask
    // Expectations are taken before the update, since a branch sees the old value
    task automatic cyc(logic uv, flag_op_e o, logic bv, cond_e cd, logic rd, logic wr,
        logic [3:0] a, logic [7:0] d);
        s = xs(s);
        r <= s;
        op <= o;
        upd_valid_i <= uv;
        branch_i <= '{bv, cd, s[27:25]};
        bus_i <= '{a, d, wr, rd};
        #1;
        if (bv) q.push_back({7'h0, tk(m, branch_i)});
        if (rd) q.push_back(a == CC_OFFSET ? m : UNMAPPED_READ);
        if (wr && a == CC_OFFSET) m = d | CC_FIXED_ONES;
        if (uv) m = nxt(m, upd_i);
        @(posedge mclk_i);
    endtask
    always @(posedge mclk_i) rd_d <= bus_i.rd;
    always @(negedge mclk_i)
    begin
        n++;
        if (branch_valid_o === 1'b1) cmp({7'h0, branch_taken_o});
        if (rd_d) cmp(rdata_o);
        if (n == 2500)
        begin
            err_count++;
            print_verdict();
        end
    end
    initial
    begin
        m = CC_RESET;
        repeat (8) @(posedge mclk_i);
        rst_n_i <= 1'b1;
        repeat (3) @(posedge mclk_i);
        cyc(0, OP_NONE, 1, COND_H, 1, 0, CC_OFFSET, 8'h00);
        cyc(0, OP_NONE, 0, COND_NONE, 0, 1, 4'h5, 8'h00);
        cyc(0, OP_NONE, 0, COND_NONE, 1, 0, 4'h5, 8'h00);
        cyc(0, OP_NONE, 0, COND_NONE, 0, 1, CC_OFFSET, 8'h00);
        cyc(0, OP_NONE, 1, COND_BCLR, 1, 0, CC_OFFSET, 8'h00);
        for (int i = 0; i < 240; i++)
        begin
            cyc(1, flag_op_e'(4'(i % 12 + 1)), 1, cond_e'(4'(i % 10 + 1)),
                0, 0, 4'h0, 8'h00);
            cyc(0, OP_NONE, 1, cond_e'(4'(i % 7 + 1)), 1, 0, CC_OFFSET, 8'h00);
            cyc(0, OP_NONE, 0, COND_NONE, 0, i % 5 == 0, CC_OFFSET, s[15:8]);
        end
        repeat (2) cyc(0, OP_NONE, 0, COND_NONE, 0, 0, CC_OFFSET, 8'h00);
        print_verdict();
    end
endmodule // cpu_condition_code_flags_bench
